// file: logic/buck_dvs_pkg.sv
package buck_dvs_pkg;

   localparam int unsigned CODE_W   = 6;
   localparam int unsigned DATA_W   = 8;
   localparam int unsigned ADDR_W   = 8;
   localparam int unsigned MV_W     = 13;
   localparam int unsigned STEP_W   = 6;

   localparam logic [ADDR_W-1:0] ALT_VOLTAGE_0_OFS      = 8'h22;
   localparam logic [ADDR_W-1:0] ALT_VOLTAGE_1_OFS      = 8'h23;
   localparam logic [ADDR_W-1:0] ALT_VOLTAGE_2_OFS      = 8'h24;
   localparam logic [ADDR_W-1:0] ALT_VOLTAGE_3_OFS      = 8'h25;
   localparam logic [ADDR_W-1:0] SERIAL_DVS_READBACK_OFS = 8'h26;

   localparam logic [CODE_W-1:0] CODE_RESET = 6'h00;
   localparam logic [DATA_W-1:0] DATA_ZERO  = 8'h00;
   localparam logic [MV_W-1:0]   BASE_MV    = 13'h0226;

   localparam logic [1:0] SEL_ALT_0 = 2'h0;
   localparam logic [1:0] SEL_ALT_1 = 2'h1;
   localparam logic [1:0] SEL_ALT_2 = 2'h2;
   localparam logic [1:0] SEL_ALT_3 = 2'h3;

   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } reg_req_s;

   typedef struct packed {
      logic              valid;
      logic [CODE_W-1:0] code;
   } serial_code_s;

endpackage

// file: logic/buck_dvs_voltage_regs.sv
`timescale 1ns/10ps
// Summary of operation
// - control pins 01 select alternate setting 1 as the buck target code.
// - control pins 10 select alternate setting 2 as the buck target code.
// - control pins 11 select alternate setting 3 as the buck target code.
// - target millivolts equal 550 plus code times the selected step size.
// - control pins 00 select alternate setting 0 as the buck target code.
// - readback register reports the latest serial DVS code in bits 5:0.
module buck_dvs_voltage_regs
   import buck_dvs_pkg::*;
(
   input  wire logic                ref_clk,
   input  wire logic                sys_rst,
   input  wire reg_req_s            reg_req,
   output logic      [DATA_W-1:0]   reg_rdata_q,
   output logic                     reg_rvalid_q,
   input  wire logic [1:0]          multipurpose_control_pin,
   input  wire serial_code_s        serial_dvs_voltage_code,
   input  wire logic [STEP_W-1:0]   first_buck_step_size,
   output logic      [CODE_W-1:0]   active_code_q,
   output logic      [MV_W-1:0]     target_mv_q
);

   logic [CODE_W-1:0] alt_q [4];
   logic [CODE_W-1:0] readback_q;

   wire logic [CODE_W-1:0] wr_code  = reg_req.wdata[CODE_W-1:0];
   wire logic              hit_ro   = reg_req.addr == SERIAL_DVS_READBACK_OFS;
   wire logic [3:0]        hit_alt  = {reg_req.addr == ALT_VOLTAGE_3_OFS,
                                       reg_req.addr == ALT_VOLTAGE_2_OFS,
                                       reg_req.addr == ALT_VOLTAGE_1_OFS,
                                       reg_req.addr == ALT_VOLTAGE_0_OFS};
   wire logic [1:0]        rd_idx   = reg_req.addr[1:0] - ALT_VOLTAGE_0_OFS[1:0];
   wire logic [CODE_W-1:0] rd_code  = hit_ro ? readback_q :
                                      (|hit_alt) ? alt_q[rd_idx] : CODE_RESET;
   wire logic [DATA_W-1:0] rd_data  = {2'h0, rd_code};

   // pins pick one of four stored codes
   wire logic [CODE_W-1:0] sel_code = alt_q[multipurpose_control_pin];
   wire logic [MV_W-1:0]   step_mv  = MV_W'(sel_code) * MV_W'(first_buck_step_size);
   wire logic [MV_W-1:0]   tgt_mv   = BASE_MV + step_mv;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_alt
         always_ff @(posedge ref_clk or posedge sys_rst)
         begin
            if (sys_rst)
               alt_q[gi] <= CODE_RESET;
            else if (reg_req.wr && hit_alt[gi])
               alt_q[gi] <= wr_code;
         end
      end
   endgenerate

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         readback_q <= CODE_RESET;
      else if (serial_dvs_voltage_code.valid)
         readback_q <= serial_dvs_voltage_code.code;
   end

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         reg_rdata_q  <= DATA_ZERO;
         reg_rvalid_q <= 1'b0;
      end
      else
      begin
         reg_rdata_q  <= reg_req.rd ? rd_data : DATA_ZERO;
         reg_rvalid_q <= reg_req.rd;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         active_code_q <= CODE_RESET;
         target_mv_q   <= BASE_MV;
      end
      else
      begin
         active_code_q <= sel_code;
         target_mv_q   <= tgt_mv;
      end
   end

   // checks
   sequence s_write_alt1;
      reg_req.wr && reg_req.addr == ALT_VOLTAGE_1_OFS;
   endsequence

   sequence s_pins_hold(logic [1:0] v);
      multipurpose_control_pin == v;
   endsequence

   a_sel_alt_one: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (s_write_alt1 ##1 (!(reg_req.wr && hit_alt[1]) and s_pins_hold(SEL_ALT_1)))
      |=> active_code_q == $past(reg_req.wdata[CODE_W-1:0], 2))
      else $error("pins 01 did not select setting 1");

   a_sel_alt_two: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      multipurpose_control_pin == SEL_ALT_2 |=> active_code_q == $past(alt_q[2]))
      else $error("pins 10 did not select setting 2");

   a_sel_alt_three: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      multipurpose_control_pin == SEL_ALT_3 |=> active_code_q == $past(alt_q[3]))
      else $error("pins 11 did not select setting 3");

   a_sel_alt_zero: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      multipurpose_control_pin == SEL_ALT_0 |=> active_code_q == $past(alt_q[0]))
      else $error("pins 00 did not select setting 0");

   a_target_mv_map: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      ##1 target_mv_q == BASE_MV
         + MV_W'(active_code_q) * MV_W'($past(first_buck_step_size)))
      else $error("target millivolts do not match code and step");

   a_readback_update: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      serial_dvs_voltage_code.valid ##1 (reg_req.rd && hit_ro)
      |=> reg_rvalid_q
         && reg_rdata_q[CODE_W-1:0] == $past(serial_dvs_voltage_code.code, 2))
      else $error("readback does not show serial code");

   a_upper_bits_zero: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      reg_rdata_q[DATA_W-1:CODE_W] == 2'h0)
      else $error("upper register bits not zero");

   a_ro_not_written: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      reg_req.wr && hit_ro && !serial_dvs_voltage_code.valid |=> $stable(readback_q))
      else $error("readback register changed on bus write");

   sequence s_read_unmapped;
      reg_req.rd && !hit_ro && !(|hit_alt);
   endsequence

   a_rvalid_after_rd: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      reg_req.rd |=> reg_rvalid_q)
      else $error("read strobe gave no read valid");

   a_rvalid_no_rd: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      !reg_req.rd |=> !reg_rvalid_q)
      else $error("read valid without read strobe");

   a_rdata_idle_zero: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      !reg_req.rd |=> reg_rdata_q == DATA_ZERO)
      else $error("read data not zero outside a read");

   a_unmapped_zero: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      s_read_unmapped |=> reg_rvalid_q && reg_rdata_q == DATA_ZERO)
      else $error("unmapped read did not return zero");

   a_ro_read_value: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      reg_req.rd && hit_ro |=> reg_rdata_q[CODE_W-1:0] == $past(readback_q))
      else $error("readback read shows wrong code");

   a_readback_load: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      serial_dvs_voltage_code.valid |=> readback_q == $past(serial_dvs_voltage_code.code))
      else $error("serial code not loaded into readback");

   a_readback_hold: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      !serial_dvs_voltage_code.valid |=> $stable(readback_q))
      else $error("readback changed without serial code");

   a_alt0_read: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      reg_req.rd && hit_alt[0] |=> reg_rdata_q[CODE_W-1:0] == $past(alt_q[0]))
      else $error("setting 0 read shows wrong code");

   a_alt2_read: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      reg_req.rd && hit_alt[2] |=> reg_rdata_q[CODE_W-1:0] == $past(alt_q[2]))
      else $error("setting 2 read shows wrong code");

   a_alt3_read: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      reg_req.rd && hit_alt[3] |=> reg_rdata_q[CODE_W-1:0] == $past(alt_q[3]))
      else $error("setting 3 read shows wrong code");

   a_alt0_write: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      reg_req.wr && hit_alt[0] |=> alt_q[0] == $past(reg_req.wdata[CODE_W-1:0]))
      else $error("setting 0 write did not land");

   a_alt2_write: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      reg_req.wr && hit_alt[2] |=> alt_q[2] == $past(reg_req.wdata[CODE_W-1:0]))
      else $error("setting 2 write did not land");

   a_alt1_hold: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      !(reg_req.wr && hit_alt[1]) |=> $stable(alt_q[1]))
      else $error("setting 1 changed without a write");

   a_alt3_hold: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      !(reg_req.wr && hit_alt[3]) |=> $stable(alt_q[3]))
      else $error("setting 3 changed without a write");

   a_zero_code_base: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      active_code_q == CODE_RESET |-> target_mv_q == BASE_MV)
      else $error("code zero does not give the base voltage");

   a_target_floor: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      target_mv_q >= BASE_MV)
      else $error("target millivolts below the base voltage");

endmodule

// file: testbench/pin_model.sv
`timescale 1ns/10ps
module pin_model
   import buck_dvs_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic [1:0] sel,
   input  wire logic [6:0] ser,
   output serial_code_s    code,
   output logic [1:0]      pins
);
   initial code = '0;
   initial pins = '0;
   // pins and serial code change only just after an edge
   always @(posedge ref_clk)
   begin
      pins <= sel;
      code <= ser;
   end
endmodule

// file: testbench/test_buck_dvs_voltage_regs.sv
`timescale 1ns/10ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin num_errors++; \
   $display("FAIL %s exp %h got %h", n, e, s); end end
module test_buck_dvs_voltage_regs;
   import buck_dvs_pkg::*;
   logic              ref_clk = 0;
   logic              sys_rst = 1;
   reg_req_s          req = '0;
   logic [1:0]        sel = 0, pins;
   logic [6:0]        ser = 0;
   logic [STEP_W-1:0] step = 6'h0a;
   logic [DATA_W-1:0] rdata, got, notes[$];
   logic              rvalid;
   logic [CODE_W-1:0] act, codes[4];
   logic [MV_W-1:0]   mv;
   serial_code_s      scode;
   int                num_errors = 0, samples_checked = 0, i;
   pin_model pm_u (.ref_clk(ref_clk), .sel(sel), .ser(ser), .code(scode), .pins(pins));
   buck_dvs_voltage_regs dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_req(req),
      .reg_rdata_q(rdata), .reg_rvalid_q(rvalid), .multipurpose_control_pin(pins),
      .serial_dvs_voltage_code(scode), .first_buck_step_size(step),
      .active_code_q(act), .target_mv_q(mv));
   initial forever #12.5 ref_clk = ~ref_clk;
   task automatic stop_test;
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // one register access; a read notes its expected byte
   task automatic acc(input logic wr, input logic [7:0] a, d, e);
      req <= '{wr: wr, rd: !wr, addr: a, wdata: d};
      if (!wr) notes.push_back(e);
      @(posedge ref_clk);
      req <= '0;
      @(posedge ref_clk);
   endtask
   always @(posedge ref_clk)
   begin
      if (rvalid === 1'b1)
      begin
         got = (notes.size() > 0) ? notes.pop_front() : 8'hxx;
         `CHK("rdata", got, rdata)
      end
   end
   initial
   begin
      #100us;
      num_errors++;
      stop_test;
   end
   initial
   begin
      void'($urandom(22193));
      repeat (12) @(posedge ref_clk);
      sys_rst <= 0;
      @(posedge ref_clk);
      for (i = 0; i < 4; i++)
      begin
         codes[i] = CODE_W'($urandom);
         acc(1, 8'(i + 34), {2'b11, codes[i]}, 8'h00);
      end
      for (i = 0; i < 4; i++) acc(0, 8'(i + 34), 0, {2'b00, codes[i]});
      acc(0, 8'h40, 0, 0);
      $display("register test done");
      for (i = 0; i < 4; i++)
      begin
         sel <= 2'(i);
         step <= STEP_W'($urandom);
         repeat (3) @(posedge ref_clk);
         `CHK("code", codes[i], act)
         `CHK("mv", BASE_MV + codes[i] * step, mv)
         // rewrite the selected setting while the pins hold it
         codes[i] = CODE_W'($urandom);
         acc(1, 8'(i + 34), {2'b01, codes[i]}, 8'h00);
         repeat (2) @(posedge ref_clk);
         `CHK("code", codes[i], act)
         `CHK("mv", BASE_MV + codes[i] * step, mv)
      end
      $display("pin select test done");
      ser <= {1'b1, 6'(codes[0] ^ 6'h2a)};
      @(posedge ref_clk);
      ser <= 0;
      @(posedge ref_clk);
      // read in the cycle right after the serial code lands
      acc(0, 8'h26, 8'h00, {2'b00, codes[0] ^ 6'h2a});
      acc(1, 8'h26, 8'hff, 8'h00);
      acc(0, 8'h26, 0, {2'b00, codes[0] ^ 6'h2a});
      repeat (3) @(posedge ref_clk);
      `CHK("pending", 0, notes.size())
      $display("serial readback test done");
      stop_test;
   end
endmodule
